// ===== verilog/lcd_host_command_decoder.v
// Host command decoder and display RAM address generator for an LCD driver.
// Assumes host bytes arrive as one-cycle strobes already in the sys_clk domain
// from the host interface logic; RAM sits outside behind ram_* ports.
`include "lcd_cmd_consts.vh"

module lcd_host_command_decoder
#(
  parameter VERSION_BIT = 1'b0, // Arbitrary revision value
  parameter NV_OPTION   = 1'b1,
  parameter POWER_STEPS = 4
)
(
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       host_strobe,
  input  wire       host_is_data,
  input  wire       host_read,
  input  wire [7:0] host_wdata,
  input  wire       serial_8bit_mode,
  input  wire       serial_9bit_mode,
  input  wire       strap_pin_pad,
  input  wire       por_ctrl_pad,
  input  wire       nv_op_success,
  input  wire       nv_action_flag,
  input  wire [7:0] ram_rdata,
  output reg        ram_we,
  output reg        ram_re,
  output reg  [3:0] ram_row_group,
  output reg  [7:0] ram_column,
  output reg  [7:0] ram_wdata,
  output reg        host_rvalid,
  output reg  [7:0] host_rdata,
  output reg  [5:0] scroll_offset,
  output reg  [7:0] bias_pot_value,
  output reg  [5:0] pot_offset,
  output reg  [6:0] mux_rate,
  output reg  [1:0] frame_rate_sel,
  output reg  [1:0] bias_ratio_sel,
  output reg  [1:0] temp_comp_sel,
  output reg  [2:0] power_ctrl,
  output reg        seg_all_on,
  output reg        seg_inverse,
  output reg        row_mirror,
  output reg        column_mirror,
  output reg        sleep_exit,
  output reg        power_on,
  output reg        drivers_on,
  output reg        display_on_flag
);

////////////////////////////////////////////////////////////////////////////////
// Synchronised straps and pointer state

reg        strap_meta_ff;
reg        strap_pin_state_ff;
reg        por_meta_ff;
reg        por_state_ff;
reg  [3:0] row_group_pointer_ff;
reg  [7:0] column_pointer_ff;
reg  [2:0] auto_step_config_ff;
reg        partial_en_ff;
reg  [5:0] last_row_index_ff;
reg  [5:0] partial_first_row_ff;
reg  [5:0] partial_last_row_ff;
reg  [4:0] nv_ctrl_ff;
reg        display_en_ff;
reg  [7:0] pending_op_ff;
reg        arg_wait_ff;
reg  [1:0] status_left_ff;
reg        step_pending_ff;
reg        rd_pending_ff;
reg  [1:0] pwr_phase_ff;
reg  [2:0] pwr_cnt_ff;

reg  [3:0] nxt_row_group;
reg  [7:0] nxt_column;

wire serial_mode = serial_8bit_mode | serial_9bit_mode;
wire cmd_strobe  = host_strobe & ~host_is_data;
wire data_strobe = host_strobe & host_is_data;
wire [7:0] status_first  = {strap_pin_state_ff, column_mirror, row_mirror,
                            auto_step_config_ff[`AC_WRAP_BIT], display_on_flag,
                            nv_op_success, NV_OPTION, nv_action_flag};
wire [7:0] status_second = {VERSION_BIT, por_state_ff, pot_offset};

function [3:0] step_group;
  input [3:0] g;
  input       neg;
  begin
    if (neg)
      step_group = (g == 4'h0) ? `ROW_GROUP_LAST : g - 4'h1;
    else
      step_group = (g >= `ROW_GROUP_LAST) ? 4'h0 : g + 4'h1;
  end
endfunction

// Mirror applies on the RAM side only; image changes as RAM is rewritten.
function [7:0] ram_col;
  input [7:0] c;
  input       mx;
  begin
    ram_col = mx ? (`COL_MIRROR_BASE - c) : c;
  end
endfunction

// Control defaults, shared by the reset pin and the reset command
task load_defaults;
begin
  row_group_pointer_ff <= 4'h0;
  column_pointer_ff    <= 8'h00;
  auto_step_config_ff  <= `AUTO_STEP_RESET;
  scroll_offset        <= 6'h00;
  bias_pot_value       <= `POT_RESET;
  pot_offset           <= 6'h00;
  partial_en_ff        <= 1'b0;
  frame_rate_sel       <= `FRAME_RATE_RESET;
  bias_ratio_sel       <= `BIAS_RATIO_RESET;
  temp_comp_sel        <= `TEMP_COMP_RESET;
  power_ctrl           <= `POWER_CTRL_RESET;
  seg_all_on           <= 1'b0;
  seg_inverse          <= 1'b0;
  row_mirror           <= 1'b0;
  column_mirror        <= 1'b0;
  display_en_ff        <= 1'b0;
  last_row_index_ff    <= `LAST_ROW_RESET;
  partial_first_row_ff <= `PART_FIRST_RESET;
  partial_last_row_ff  <= `PART_LAST_RESET;
  nv_ctrl_ff           <= `NV_CTRL_RESET;
end
endtask

////////////////////////////////////////////////////////////////////////////////
// Auto-step after a data access

always @*
begin
  nxt_row_group = row_group_pointer_ff;
  nxt_column    = column_pointer_ff;
  if (!auto_step_config_ff[`AC_ORDER_BIT])
  begin
    if (column_pointer_ff < `COL_LAST)
      nxt_column = column_pointer_ff + 8'h01;
    else if (auto_step_config_ff[`AC_WRAP_BIT])
    begin
      nxt_column    = 8'h00;
      nxt_row_group = step_group(row_group_pointer_ff, auto_step_config_ff[`AC_SIGN_BIT]);
    end
    // Wrap off: column holds at page end.
  end
  else
  begin
    if (auto_step_config_ff[`AC_SIGN_BIT] ? (row_group_pointer_ff != 4'h0)
                                          : (row_group_pointer_ff < `ROW_GROUP_LAST))
      nxt_row_group = step_group(row_group_pointer_ff, auto_step_config_ff[`AC_SIGN_BIT]);
    else if (auto_step_config_ff[`AC_WRAP_BIT])
    begin
      nxt_row_group = step_group(row_group_pointer_ff, auto_step_config_ff[`AC_SIGN_BIT]);
      nxt_column    = (column_pointer_ff < `COL_LAST) ? column_pointer_ff + 8'h01 : 8'h00;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Command decode and control registers

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
  begin
    load_defaults;
    pending_op_ff        <= 8'h00;
    arg_wait_ff          <= 1'b0;
    status_left_ff       <= 2'd0;
    strap_meta_ff        <= 1'b0;
    strap_pin_state_ff   <= 1'b0;
    por_meta_ff          <= 1'b0;
    por_state_ff         <= 1'b0;
    step_pending_ff      <= 1'b0;
    rd_pending_ff        <= 1'b0;
    ram_we               <= 1'b0;
    ram_re               <= 1'b0;
    ram_row_group        <= 4'h0;
    ram_column           <= 8'h00;
    ram_wdata            <= 8'h00;
    host_rvalid          <= 1'b0;
    host_rdata           <= 8'h00;
  end
  else
  begin
    strap_meta_ff      <= strap_pin_pad;
    strap_pin_state_ff <= strap_meta_ff;
    por_meta_ff        <= por_ctrl_pad;
    por_state_ff       <= por_meta_ff;
    ram_we             <= 1'b0;
    ram_re             <= 1'b0;
    host_rvalid        <= rd_pending_ff;
    step_pending_ff    <= 1'b0;
    rd_pending_ff      <= ram_re;
    if (rd_pending_ff)
      host_rdata <= ram_rdata;
    if (step_pending_ff)
    begin
      row_group_pointer_ff <= nxt_row_group;
      column_pointer_ff    <= nxt_column;
    end
    if (data_strobe && !step_pending_ff)
    begin
      // One data byte at the current pointers; stepping follows a cycle later.
      ram_row_group   <= row_group_pointer_ff;
      ram_column      <= ram_col(column_pointer_ff, column_mirror);
      ram_wdata       <= host_wdata;
      ram_we          <= ~host_read;
      ram_re          <= host_read;
      step_pending_ff <= 1'b1;
    end
    else if (cmd_strobe && host_read)
    begin
      host_rvalid    <= 1'b1;
      host_rdata     <= (status_left_ff == 2'd1) ? status_second : status_first;
      status_left_ff <= (status_left_ff == 2'd1) ? 2'd0 : 2'd1;
    end
    else if (cmd_strobe && arg_wait_ff)
    begin
      arg_wait_ff <= 1'b0;
      case (pending_op_ff)
        `OP_POT:        bias_pot_value       <= host_wdata;
        `OP_LAST_ROW:   last_row_index_ff    <= host_wdata[5:0];
        `OP_PART_FIRST: partial_first_row_ff <= host_wdata[5:0];
        `OP_PART_LAST:  partial_last_row_ff  <= host_wdata[5:0];
        `OP_NV_CTRL:    nv_ctrl_ff           <= host_wdata[4:0];
        `OP_NV_MASK:    pot_offset           <= host_wdata[5:0];
        default:        ;
      endcase
    end
    else if (cmd_strobe)
    begin
      status_left_ff <= 2'd0;
      casez (host_wdata)
        8'b0000????: column_pointer_ff[3:0] <= host_wdata[3:0];
        8'b0001????: column_pointer_ff[7:4] <= host_wdata[3:0];
        8'b001001??: temp_comp_sel          <= host_wdata[1:0];
        8'b00101???: power_ctrl             <= host_wdata[2:0];
        8'b01??????: scroll_offset          <= host_wdata[5:0];
        8'b1011????: row_group_pointer_ff   <= host_wdata[3:0];
        8'b1000010?: partial_en_ff          <= host_wdata[0];
        8'b10001???: auto_step_config_ff    <= host_wdata[2:0];
        8'b101000??: frame_rate_sel         <= host_wdata[1:0];
        8'b1010010?: seg_all_on             <= host_wdata[0];
        8'b1010011?: seg_inverse            <= host_wdata[0];
        // Display enable is refused while a nonvolatile operation runs.
        8'b1010111?: display_en_ff          <= host_wdata[0] & ~nv_ctrl_ff[3];
        8'b11000??0:
        begin
          row_mirror    <= host_wdata[2];
          column_mirror <= host_wdata[1];
        end
        8'b111010??: bias_ratio_sel         <= host_wdata[1:0];
        // Pointers and control return to defaults; RAM is untouched.
        `OP_SYS_RESET: load_defaults;
        8'b001100??, 8'b1110010?, `OP_POT, `OP_LAST_ROW, `OP_PART_FIRST,
        `OP_PART_LAST, `OP_NV_CTRL, `OP_NV_MASK, 8'b111101??:
        begin
          pending_op_ff <= host_wdata;
          arg_wait_ff   <= 1'b1;
        end
        `OP_STATUS_PREFIX: status_left_ff <= serial_mode ? 2'd2 : 2'd0;
        // Data reads need no arming, so the read prefix is taken and dropped.
        `OP_READ_PREFIX:   ;
        default: ;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Multiplex rate and display power sequence

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
    mux_rate <= 7'd64;
  else if (partial_en_ff)
    mux_rate <= {1'b0, partial_last_row_ff} - {1'b0, partial_first_row_ff} + 7'd1;
  else
    mux_rate <= {1'b0, last_row_index_ff} + 7'd1;
end

// Drivers come on only after power has had time to settle. Off is immediate.
always @(posedge sys_clk or posedge reset)
begin
  if (reset)
  begin
    pwr_phase_ff    <= 2'd0;
    pwr_cnt_ff      <= 3'd0;
    sleep_exit      <= 1'b0;
    power_on        <= 1'b0;
    drivers_on      <= 1'b0;
    display_on_flag <= 1'b0;
  end
  else if (!display_en_ff)
  begin
    pwr_phase_ff    <= 2'd0;
    pwr_cnt_ff      <= 3'd0;
    sleep_exit      <= 1'b0;
    power_on        <= 1'b0;
    drivers_on      <= 1'b0;
    display_on_flag <= 1'b0;
  end
  else
  begin
    display_on_flag <= 1'b1;
    case (pwr_phase_ff)
      2'd0:
      begin
        sleep_exit   <= 1'b1;
        pwr_phase_ff <= 2'd1;
      end
      2'd1:
      begin
        power_on     <= 1'b1;
        pwr_cnt_ff   <= 3'd0;
        pwr_phase_ff <= 2'd2;
      end
      2'd2:
      begin
        if (pwr_cnt_ff == POWER_STEPS[2:0] - 3'd1)
        begin
          drivers_on   <= 1'b1;
          pwr_phase_ff <= 2'd3;
        end
        else
          pwr_cnt_ff <= pwr_cnt_ff + 3'd1;
      end
      default: ;
    endcase
  end
end

endmodule

// ===== verilog/lcd_cmd_consts.vh
// Constants for the LCD host command decoder: opcodes, field positions,
// reset values and pointer limits. Definitions only.
`ifndef LCD_CMD_CONSTS_VH
`define LCD_CMD_CONSTS_VH

`define COL_LAST          8'hBF
`define COL_MIRROR_BASE   8'h3F
`define ROW_GROUP_LAST    4'h8
`define POT_RESET         8'h49
`define LAST_ROW_RESET    6'h3F
`define PART_FIRST_RESET  6'h00
`define PART_LAST_RESET   6'h3F
`define AUTO_STEP_RESET   3'h1
`define BIAS_RATIO_RESET  2'h3
`define FRAME_RATE_RESET  2'h1
`define TEMP_COMP_RESET   2'h0
`define POWER_CTRL_RESET  3'h6
`define NV_CTRL_RESET     5'h00

`define AC_WRAP_BIT       0
`define AC_ORDER_BIT      1
`define AC_SIGN_BIT       2

`define OP_POT            8'h81
`define OP_SYS_RESET      8'hE2
`define OP_NOP            8'hE3
`define OP_LAST_ROW       8'hF1
`define OP_PART_FIRST     8'hF2
`define OP_PART_LAST      8'hF3
`define OP_NV_CTRL        8'hF8
`define OP_NV_MASK        8'hF9
`define OP_STATUS_PREFIX  8'hFE
`define OP_READ_PREFIX    8'hFF

`endif

// ===== verification/lcd_cmd_checker.sv
// Port-level checker for the LCD host command decoder.
// Assumes host strobes are spaced as the decoder's contract allows.
module lcd_cmd_checker
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       host_strobe,
  input wire logic       host_is_data,
  input wire logic       host_read,
  input wire logic [7:0] host_wdata,
  input wire logic       ram_we,
  input wire logic       ram_re,
  input wire logic       host_rvalid,
  input wire logic [7:0] bias_pot_value,
  input wire logic [6:0] mux_rate,
  input wire logic       seg_all_on,
  input wire logic       seg_inverse,
  input wire logic       sleep_exit,
  input wire logic       power_on,
  input wire logic       drivers_on,
  input wire logic       display_on_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  wire cmd_wr = host_strobe && !host_is_data && !host_read;
  wire dat_wr = host_strobe && host_is_data && !host_read;
  default clocking dflt @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  write_strobe_a: assert property (dat_wr && !$past(dat_wr) |=> ram_we)
    else $error("data write gave no RAM write");
  write_cause_a: assert property (ram_we |-> $past(dat_wr))
    else $error("RAM write without data write");
  read_path_a: assert property (host_strobe && host_is_data && host_read |=> ram_re ##2 host_rvalid)
    else $error("data read timing wrong");
  status_reply_a: assert property (host_strobe && !host_is_data && host_read |=> host_rvalid)
    else $error("status read gave no reply");
  pot_argument_a: assert property (cmd_wr && host_wdata == 8'h81 ##1 cmd_wr |=> bias_pot_value == $past(host_wdata))
    else $error("potentiometer argument not applied");
  reset_default_a: assert property ($fell(reset) |-> bias_pot_value == 8'h49 && mux_rate == 7'h40)
    else $error("defaults wrong after reset");
  all_on_cmd_a: assert property (cmd_wr && host_wdata[7:1] == 7'h52 |=> seg_all_on == $past(host_wdata[0]))
    else $error("all-on bit not loaded");
  inverse_cmd_a: assert property (cmd_wr && host_wdata[7:1] == 7'h53 |=> seg_inverse == $past(host_wdata[0]))
    else $error("inverse bit not loaded");
  enable_wake_a: assert property (cmd_wr && host_wdata == 8'hAF |-> ##2 display_on_flag && sleep_exit)
    else $error("display enable did not wake");
  power_order_a: assert property (drivers_on |-> power_on && sleep_exit)
    else $error("drivers on before power");
  drivers_late_a: assert property ($rose(power_on) |-> ##[1:8] drivers_on)
    else $error("drivers never followed power");
  cover property (cmd_wr && host_wdata == 8'h81);
  cover property ($rose(drivers_on));
  cover property (host_rvalid);
endmodule

bind lcd_host_command_decoder lcd_cmd_checker chk_u
(
  .sys_clk, .reset, .host_strobe, .host_is_data, .host_read, .host_wdata, .ram_we, .ram_re,
  .host_rvalid, .bias_pot_value, .mux_rate, .seg_all_on, .seg_inverse, .sleep_exit, .power_on,
  .drivers_on, .display_on_flag
);

// ===== verification/lcd_host_model.sv
// Host processor model issuing command and data bytes as strobes.
// Assumes each call is entered at a rising edge of sys_clk.
module lcd_host_model
(
  input  wire logic       sys_clk,
  output logic            host_strobe,
  output logic            host_is_data,
  output logic            host_read,
  output logic [7:0]      host_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    host_strobe = 1'b0;
    host_is_data = 1'b0;
    host_read = 1'b0;
    host_wdata = 8'h00;
  end
  // Gap 0 keeps the strobe up for a back-to-back byte
  task automatic xfer(input logic d, input logic r, input logic [7:0] b, input int gap);
    host_strobe <= 1'b1;
    host_is_data <= d;
    host_read <= r;
    host_wdata <= b;
    @(posedge sys_clk);
    if (gap > 0)
    begin
      host_strobe <= 1'b0;
      // Released bus shows garbage, not the last byte
      host_wdata <= ~b;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
endmodule

// ===== verification/tb_lcd_host_command_decoder.sv
// Self-checking bench for the LCD host command decoder.
// Assumes RAM outside the block; a stub answers reads.
module tb_lcd_host_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, host_strobe, host_is_data, host_read, ram_we, ram_re, host_rvalid;
  logic seg_all_on, seg_inverse, row_mirror, column_mirror, sleep_exit, power_on, drivers_on;
  logic display_on_flag, strap_pin_pad, por_ctrl_pad, nv_op_success, nv_action_flag, serial_8bit_mode;
  logic [7:0] host_wdata, ram_rdata, ram_column, ram_wdata, host_rdata, bias_pot_value;
  logic [5:0] scroll_offset, pot_offset;
  logic [3:0] ram_row_group;
  logic [6:0] mux_rate;
  logic [2:0] power_ctrl;
  logic [1:0] frame_rate_sel, bias_ratio_sel, temp_comp_sel;
  logic [19:0] wlog[$];
  logic [7:0]  rlog[$];
  int n_errors = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////////
  lcd_host_model host_u (.sys_clk, .host_strobe, .host_is_data, .host_read, .host_wdata);
  lcd_host_command_decoder dut_u
  (
    .sys_clk, .reset, .host_strobe, .host_is_data, .host_read, .host_wdata,
    .serial_8bit_mode, .serial_9bit_mode(1'b0), .strap_pin_pad, .por_ctrl_pad,
    .nv_op_success, .nv_action_flag, .ram_rdata, .ram_we, .ram_re, .ram_row_group, .ram_column,
    .ram_wdata, .host_rvalid, .host_rdata, .scroll_offset, .bias_pot_value, .pot_offset, .mux_rate,
    .frame_rate_sel, .bias_ratio_sel, .temp_comp_sel, .power_ctrl, .seg_all_on, .seg_inverse,
    .row_mirror, .column_mirror, .sleep_exit, .power_on, .drivers_on, .display_on_flag
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // RAM stub: address-derived byte on read, toggling junk otherwise
  always @(posedge sys_clk)
  begin
    ram_rdata <= ram_re ? ({4'h0, ram_row_group} ^ ram_column) : ~ram_rdata;
    if (ram_we === 1'b1)
      wlog.push_back({ram_row_group, ram_column, ram_wdata});
    if (host_rvalid === 1'b1)
      rlog.push_back(host_rdata);
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] b, input int gap = 4);
    host_u.xfer(1'b0, 1'b0, b, gap);
  endtask
  task automatic wr(input logic [7:0] b);
    host_u.xfer(1'b1, 1'b0, b, 4);
  endtask
  task automatic at(input logic [3:0] g, input logic [7:0] c);
    cmd({4'hB, g}, 0);
    cmd({4'h0, c[3:0]}, 0);
    cmd({4'h1, c[7:4]});
  endtask
  task automatic expw(input logic [3:0] g, input logic [7:0] c, input logic [7:0] d);
    logic [19:0] e;
    e = (wlog.size() != 0) ? wlog.pop_front() : 20'hFFFFF;
    chk({4'h0, e[19:16]}, {4'h0, g});
    chk(e[15:8], c);
    chk(e[7:0], d);
  endtask
  task automatic expr(input logic [7:0] d);
    chk((rlog.size() != 0) ? rlog.pop_front() : ~d, d);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("unexpected at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    results();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    strap_pin_pad = 1'b1;
    por_ctrl_pad = 1'b1;
    nv_op_success = 1'b0;
    nv_action_flag = 1'b1;
    serial_8bit_mode = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(bias_pot_value, 8'h49);
    chk({1'b0, mux_rate}, 8'h40);
    chk({5'h0, power_ctrl}, 8'h06);
    for (int i = 0; i < 4; i++)
    begin
      cmd(8'hA0 | 8'(i));
      chk({6'h0, frame_rate_sel}, 8'(i));
      cmd(8'hE8 | 8'(i));
      chk({6'h0, bias_ratio_sel}, 8'(i));
    end
    cmd(8'h81, 0);
    cmd(8'hE2);
    chk(bias_pot_value, 8'hE2);
    cmd(8'h81, 0);
    cmd(8'h20);
    cmd(8'h6A);
    chk({2'h0, scroll_offset}, 8'h2A);
    // Host keeps last row >= partial last >= partial first + 9
    cmd(8'hF1, 0);
    cmd(8'h1F);
    chk({1'b0, mux_rate}, 8'h20);
    cmd(8'hF2, 0);
    cmd(8'h05);
    cmd(8'hF3, 0);
    cmd(8'h14);
    cmd(8'h85);
    chk({1'b0, mux_rate}, 8'h10);
    cmd(8'h84);
    cmd(8'hE1);
    cmd(8'hE3);
    chk(bias_pot_value, 8'h20);
    chk({1'b0, mux_rate}, 8'h20);
    cmd(8'hA5);
    cmd(8'hA7);
    chk({6'h0, seg_all_on, seg_inverse}, 8'h03);
    at(4'h3, 8'hBE);
    wr(8'h11);
    wr(8'h22);
    wr(8'h33);
    at(4'h8, 8'hBF);
    wr(8'h44);
    wr(8'h55);
    expw(4'h3, 8'hBE, 8'h11);
    expw(4'h3, 8'hBF, 8'h22);
    expw(4'h4, 8'h00, 8'h33);
    expw(4'h8, 8'hBF, 8'h44);
    expw(4'h0, 8'h00, 8'h55);
    cmd(8'h88);
    at(4'h2, 8'hBF);
    wr(8'h66);
    wr(8'h77);
    expw(4'h2, 8'hBF, 8'h66);
    expw(4'h2, 8'hBF, 8'h77);
    cmd(8'h8D);
    at(4'h0, 8'hBF);
    wr(8'h88);
    wr(8'h99);
    expw(4'h0, 8'hBF, 8'h88);
    expw(4'h8, 8'h00, 8'h99);
    cmd(8'h8B);
    at(4'h7, 8'h05);
    wr(8'h01);
    wr(8'h02);
    wr(8'h03);
    expw(4'h7, 8'h05, 8'h01);
    expw(4'h8, 8'h05, 8'h02);
    expw(4'h0, 8'h06, 8'h03);
    cmd(8'h89);
    cmd(8'hC2);
    at(4'h1, 8'h05);
    wr(8'hAA);
    expw(4'h1, 8'h3A, 8'hAA);
    cmd(8'hC4);
    chk({6'h0, row_mirror, column_mirror}, 8'h02);
    cmd(8'hC0);
    host_u.xfer(1'b1, 1'b1, 8'h00, 6);
    expr(8'h07);
    cmd(8'hF9, 0);
    cmd(8'h15);
    host_u.xfer(1'b0, 1'b1, 8'h00, 4);
    host_u.xfer(1'b0, 1'b1, 8'h00, 4);
    expr(8'h93);
    expr(8'h55);
    serial_8bit_mode <= 1'b1;
    cmd(8'hFE, 0);
    host_u.xfer(1'b0, 1'b1, 8'h00, 4);
    expr(8'h93);
    serial_8bit_mode <= 1'b0;
    cmd(8'h26);
    cmd(8'h2B);
    chk({3'h0, temp_comp_sel, power_ctrl}, 8'h13);
    cmd(8'hAF);
    for (int i = 0; i < 20 && drivers_on !== 1'b1; i++)
      @(posedge sys_clk);
    chk({4'h0, sleep_exit, power_on, drivers_on, display_on_flag}, 8'h0F);
    cmd(8'hE2);
    chk(bias_pot_value, 8'h49);
    chk({6'h0, frame_rate_sel}, 8'h01);
    chk({2'h0, pot_offset}, 8'h00);
    chk({7'h0, display_on_flag}, 8'h00);
    chk({3'h0, temp_comp_sel, power_ctrl}, 8'h06);
    chk({6'h0, seg_all_on, seg_inverse}, 8'h00);
    wr(8'hCC);
    expw(4'h0, 8'h00, 8'hCC);
    results();
  end
endmodule
